//--- lmhc_pkg.sv
// constants, field layouts and types of the line monitor and hook control block
// assumes one 25 MHz pclk and an APB master with 32-bit data
// What this block and the host side must do
// (RL1) monitor enable on-hook streams digitized ring samples
// (RL2) force bit adds low-power monitor converter selection
// (RL3) controller clears monitor enable before going off-hook
// (RL4) gain select attenuates low-power monitor input
// (RL5) coupling reset bit resets ring AC coupling
// (RL6) between-ring caller ID set, receive, clear sequence
// (RL7) controller uses full-wave detect for reversals
// (RL8) polarity reversal sets a ring edge flag
// (RL9) controller waits 40 ms to classify edges
// (RL10) monitor samples may carry DC offset
// (RL11) decoder filters out monitor DC offset
// (RL12) autocal disable suppresses off-hook calibration
// (RL13) force while off-hook drops line, skips counter; the block drops the line only while monitor enable is clear
// (RL14) no serial samples while forced on-hook
// (RL15) controller judges parallel devices from line level
// (RL16) controller sets monitor enable 30 ms after return
// (RL17) normal off-hook blocks data for 1548 samples
// (RL18) return from forced on-hook skips the counter
// (RL19) host mutes upstream around acknowledge tone
// (RL20) overload at full level drops termination, flags
// (RL21) controller enables overload protect 25 ms after
// (RL22) off-hook counter counts sample ticks from hook
package lmhc_pkg;

  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int FS_HZ_DEFAULT  = 8_000;
  localparam int FS_DIV_DEFAULT = CLK_HZ / FS_HZ_DEFAULT;
  localparam int OFFHOOK_FS     = 1548;  // sample periods of data blocking
  localparam int CAL_FS         = 512;   // sample periods of one calibration
  localparam int HOOK_CNT_W     = 11;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE = 8'h0c;

  // control register, bits 9..0
  typedef struct packed {
    logic [2:0] receive_gain_select;           // 9:7
    logic       overload_protect_enable;       // 6
    logic       autocal_disable;               // 5
    logic       full_wave_ring_detect_enable;  // 4
    logic       ring_coupling_reset;           // 3
    logic       monitor_select_force_onhook;   // 2
    logic       hook_state_control;            // 1
    logic       line_monitor_enable;           // 0
  } lmhc_ctrl_t;
  localparam int         CTRL_W   = 10;
  localparam lmhc_ctrl_t CTRL_RST = '0;

  // status register bits; 2..0 are sticky, write one to clear
  localparam int ST_POS_FLAG  = 0;
  localparam int ST_NEG_FLAG  = 1;
  localparam int ST_OVL_FLAG  = 2;
  localparam int ST_OVL_TRIP  = 3;
  localparam int ST_OFFHOOK   = 4;
  localparam int ST_FORCED    = 5;
  localparam int ST_BLOCKED   = 6;
  localparam int ST_CAL       = 7;
  localparam int ST_MON       = 8;
  localparam int ST_MON_LP    = 9;
  localparam int ST_FAST_DCT  = 10;
  localparam int STATUS_W     = 11;

  localparam int          LEVEL_W        = 5;
  localparam logic [4:0]  OVERLOAD_LEVEL = 5'h1f;
  localparam int          SAMPLE_W       = 16;

  // low-power monitor attenuation, Q8: 0, 1, 2.2, 3.5, 5 dB
  localparam logic [8:0] ATT_0DB0 = 9'h100;
  localparam logic [8:0] ATT_1DB0 = 9'h0e4;
  localparam logic [8:0] ATT_2DB2 = 9'h0c6;
  localparam logic [8:0] ATT_3DB5 = 9'h0ab;
  localparam logic [8:0] ATT_5DB0 = 9'h090;

  // hook sequencer, one-hot
  typedef enum logic [4:0] {
    HK_ONHOOK  = 5'b00001,
    HK_SETTLE  = 5'b00010,
    HK_OFFHOOK = 5'b00100,
    HK_FORCED  = 5'b01000,
    HK_RECAL   = 5'b10000
  } lmhc_hook_t;

  // line-side outputs travelling together
  typedef struct packed {
    logic hook_drive;
    logic dc_term_enable;
    logic present_800_ohm;
    logic hookswitch_current_reduce;
    logic ac_coupling_reset;
    logic full_wave_mode;
    logic monitor_power_normal;
    logic monitor_power_lowpower;
    logic fast_dct_mode;
    logic calibrating;
    logic data_path_block;
  } lmhc_line_t;

endpackage

//--- lmhc_mon_conv.sv
// monitor converter back end: attenuation and serial sample stream
// assumes sample_in is already synchronised and fs_tick is a pclk pulse
`timescale 1ns/100ps
`default_nettype none
module lmhc_mon_conv
  import lmhc_pkg::*;
#(
  parameter int DW = SAMPLE_W
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          fs_tick,
  input  wire logic          enable,
  input  wire logic          lowpower,
  input  wire logic [2:0]    atten_sel,
  input  wire logic [DW-1:0] sample_in,
  output logic               serial_sample_out,
  output logic               serial_frame,
  output logic [DW-1:0]      sample_q
);

  // ---------------------------------------------------------------
  // attenuation
  // ---------------------------------------------------------------
  function automatic logic [8:0] att_coef(input logic [2:0] sel);
    case (sel)
      3'h1:    att_coef = ATT_1DB0;
      3'h2:    att_coef = ATT_2DB2;
      3'h3:    att_coef = ATT_3DB5;
      3'h4:    att_coef = ATT_5DB0;
      default: att_coef = ATT_0DB0;
    endcase
  endfunction

  // attenuation only applies to the low-power converter [RL4]
  wire logic [8:0]       coef    = lowpower ? att_coef(atten_sel) : ATT_0DB0;
  wire logic signed [DW+9:0] product = $signed(sample_in) * $signed({1'b0, coef});
  // no offset removal here: a DC offset of the converter passes through [RL10]
  wire logic [DW-1:0]    scaled  = product[DW+7:8];

  logic [DW-1:0] shift_q;
  logic [5:0]    bits_q;

  // load on each sample tick, shift out msb first; silent when disabled [RL1]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q  <= '0;
      bits_q   <= '0;
      sample_q <= '0;
    end else if (!enable) begin
      shift_q  <= '0;
      bits_q   <= '0;
    end else if (fs_tick) begin
      shift_q  <= scaled;
      sample_q <= scaled;
      bits_q   <= 6'(DW);
    end else if (bits_q != 6'h00) begin
      shift_q <= {shift_q[DW-2:0], 1'b0};
      bits_q  <= bits_q - 6'h01;
    end
  end

  // frame marks the msb bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_sample_out <= 1'b0;
      serial_frame      <= 1'b0;
    end else begin
      serial_sample_out <= enable && (bits_q != 6'h00) && shift_q[DW-1];
      serial_frame      <= enable && (bits_q == 6'(DW));
    end
  end

endmodule
`default_nettype wire

//--- lmhc_top.sv
// line monitor, hook sequencing and overload control with an APB slave
// assumes line-side pins are asynchronous to pclk and stay stable for
// several pclk periods; the sample bus is only used at sample ticks
`timescale 1ns/100ps
`default_nettype none
module lmhc_top
  import lmhc_pkg::*;
#(
  parameter int FS_DIV = FS_DIV_DEFAULT,
  parameter int OFFHOOK_TICKS = OFFHOOK_FS,
  parameter int CAL_TICKS     = CAL_FS
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ring_edge_pos_pin,
  input  wire logic                ring_edge_neg_pin,
  input  wire logic [LEVEL_W-1:0]  line_level_pin,
  input  wire logic [SAMPLE_W-1:0] ring_inputs,
  output lmhc_line_t               line_ctl,
  output logic                     serial_sample_out,
  output logic                     serial_frame
);

  // ---------------------------------------------------------------
  // sample rate enable
  // ---------------------------------------------------------------
  logic [15:0] fs_cnt_q;
  wire  logic  fs_tick = (fs_cnt_q == 16'(FS_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_cnt_q <= '0;
    end else begin
      fs_cnt_q <= fs_tick ? 16'h0000 : fs_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0]          pos_s1_q, neg_s1_q;
  logic [2:1]          pos_sx_q, neg_sx_q;
  logic [LEVEL_W-1:0]  lvl_s1_q, lvl_q;
  logic [SAMPLE_W-1:0] smp_s1_q, smp_q;

  // two flops each; the third and fourth flops of the edge pins feed edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_s1_q <= '0;
      neg_s1_q <= '0;
      pos_sx_q <= '0;
      neg_sx_q <= '0;
      lvl_s1_q <= '0;
      lvl_q    <= '0;
      smp_s1_q <= '0;
      smp_q    <= '0;
    end else begin
      pos_s1_q <= {pos_s1_q[0], ring_edge_pos_pin};
      neg_s1_q <= {neg_s1_q[0], ring_edge_neg_pin};
      pos_sx_q <= {pos_sx_q[1], pos_s1_q[1]};
      neg_sx_q <= {neg_sx_q[1], neg_s1_q[1]};
      lvl_s1_q <= line_level_pin;
      lvl_q    <= lvl_s1_q;
      smp_s1_q <= ring_inputs;
      smp_q    <= smp_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  lmhc_ctrl_t ctrl_q;
  lmhc_hook_t hook_q, hook_d;
  logic [STATUS_W-1:0] status;
  logic [SAMPLE_W-1:0] last_sample;

  wire logic setup    = psel && !penable;
  wire logic access   = psel && penable;
  wire logic hit_ctrl = (paddr == ADDR_CTRL);
  wire logic hit_stat = (paddr == ADDR_STATUS);
  wire logic hit_lvl  = (paddr == ADDR_LEVEL);
  wire logic hit_smp  = (paddr == ADDR_SAMPLE);
  wire logic mapped   = hit_ctrl || hit_stat || hit_lvl || hit_smp;
  wire logic wr_ctrl  = access && pwrite && hit_ctrl;
  wire logic wr_stat  = access && pwrite && hit_stat;

  // read data is captured in setup, so the access phase is one cycle
  wire logic [31:0] rd_mux =
      hit_ctrl ? {22'h000000, ctrl_q} :
      hit_stat ? {21'h000000, status} :
      hit_lvl  ? {27'h0000000, lvl_q} :
      hit_smp  ? {16'h0000, last_sample} : 32'h00000000;

  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !mapped;
    end
  end

  // control register; hook, force and monitor bits steer the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= lmhc_ctrl_t'(pwdata[CTRL_W-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // hook sequencer
  // ---------------------------------------------------------------
  logic [HOOK_CNT_W-1:0] hk_cnt_q;
  wire  logic settle_done = fs_tick && (hk_cnt_q == HOOK_CNT_W'(OFFHOOK_TICKS - 1));
  wire  logic recal_done  = fs_tick && (hk_cnt_q == HOOK_CNT_W'(CAL_TICKS - 1));
  wire  logic hook_bit    = ctrl_q.hook_state_control;
  wire  logic force_bit   = ctrl_q.monitor_select_force_onhook;

  always_comb begin
    hook_d = hook_q;
    case (hook_q)
      HK_ONHOOK: begin
        // counter starts at the hook request [RL22]
        if (hook_bit) hook_d = HK_SETTLE;
      end
      HK_SETTLE: begin
        if (!hook_bit) hook_d = HK_ONHOOK;
        else if (settle_done) hook_d = HK_OFFHOOK;  // [RL17]
      end
      HK_OFFHOOK: begin
        if (!hook_bit) hook_d = HK_ONHOOK;
        else if (force_bit && !ctrl_q.line_monitor_enable) hook_d = HK_FORCED;  // [RL13]
      end
      HK_FORCED: begin
        // return skips the counter; calibration only if not disabled [RL18]
        if (!hook_bit) hook_d = HK_ONHOOK;
        else if (!force_bit) hook_d = ctrl_q.autocal_disable ? HK_OFFHOOK : HK_RECAL;
      end
      HK_RECAL: begin
        if (!hook_bit) hook_d = HK_ONHOOK;
        else if (recal_done) hook_d = HK_OFFHOOK;
      end
      default: hook_d = HK_ONHOOK;
    endcase
  end

  // sample-tick counter restarts on every state change [RL22]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hook_q   <= HK_ONHOOK;
      hk_cnt_q <= '0;
    end else begin
      hook_q   <= hook_d;
      hk_cnt_q <= (hook_d != hook_q) ? '0 : hk_cnt_q + HOOK_CNT_W'(fs_tick);
    end
  end

  wire logic st_settle = (hook_q == HK_SETTLE);
  wire logic st_forced = (hook_q == HK_FORCED);
  wire logic st_recal  = (hook_q == HK_RECAL);
  wire logic st_onhook = (hook_q == HK_ONHOOK);
  wire logic line_off  = (hook_q == HK_OFFHOOK) || st_settle || st_recal;

  // ---------------------------------------------------------------
  // overload protection
  // ---------------------------------------------------------------
  logic trip_q;
  wire  logic trip_cond = line_off && ctrl_q.overload_protect_enable &&
                          (lvl_q == OVERLOAD_LEVEL);

  // trip holds until protection is disabled or the line is dropped [RL20]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= 1'b0;
    end else if (trip_cond) begin
      trip_q <= 1'b1;
    end else if (!ctrl_q.overload_protect_enable || !line_off) begin
      trip_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sticky flags, set wins over a write-one clear
  // ---------------------------------------------------------------
  logic pos_flag_q, neg_flag_q, ovl_flag_q;
  // reversals and ring edges share one edge path [RL8]
  wire  logic pos_edge = pos_sx_q[1] && !pos_sx_q[2];
  // negative half only seen with full-wave detection on [RL7]
  wire  logic neg_edge = neg_sx_q[1] && !neg_sx_q[2] && ctrl_q.full_wave_ring_detect_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_flag_q <= 1'b0;
      neg_flag_q <= 1'b0;
      ovl_flag_q <= 1'b0;
    end else begin
      pos_flag_q <= pos_edge  || (pos_flag_q && !(wr_stat && pwdata[ST_POS_FLAG]));
      neg_flag_q <= neg_edge  || (neg_flag_q && !(wr_stat && pwdata[ST_NEG_FLAG]));
      ovl_flag_q <= trip_cond || (ovl_flag_q && !(wr_stat && pwdata[ST_OVL_FLAG]));  // [RL20]
    end
  end

  // ---------------------------------------------------------------
  // monitor and line-side controls
  // ---------------------------------------------------------------
  // monitor runs only truly on-hook, so never while forced [RL1] [RL14]
  wire logic mon_active = ctrl_q.line_monitor_enable && st_onhook;
  wire logic mon_lp     = mon_active && force_bit;  // [RL2]
  wire logic fast_dct   = ctrl_q.line_monitor_enable && line_off;
  // calibration during settling unless disabled [RL12] [RL17]
  wire logic cal_now    = (st_settle && !ctrl_q.autocal_disable) || st_recal;
  wire logic blocked    = st_settle || st_recal || st_forced;

  lmhc_line_t line_d;
  always_comb begin
    line_d                           = '0;
    line_d.hook_drive                = line_off;                 // [RL13]
    line_d.dc_term_enable            = line_off && !trip_q;      // [RL20]
    line_d.present_800_ohm           = line_off && trip_q;
    line_d.hookswitch_current_reduce = line_off && trip_q;
    line_d.ac_coupling_reset         = ctrl_q.ring_coupling_reset;  // [RL5]
    line_d.full_wave_mode            = ctrl_q.full_wave_ring_detect_enable;
    line_d.monitor_power_normal      = mon_active && !force_bit;  // [RL1]
    line_d.monitor_power_lowpower    = mon_lp;                    // [RL2]
    line_d.fast_dct_mode             = fast_dct;
    line_d.calibrating               = cal_now;                   // [RL12]
    line_d.data_path_block           = blocked;                   // [RL17]
  end

  // registered so the line pins never glitch on decode changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ctl <= '0;
    end else begin
      line_ctl <= line_d;
    end
  end

  always_comb begin
    status              = '0;
    status[ST_POS_FLAG] = pos_flag_q;
    status[ST_NEG_FLAG] = neg_flag_q;
    status[ST_OVL_FLAG] = ovl_flag_q;
    status[ST_OVL_TRIP] = trip_q;
    status[ST_OFFHOOK]  = line_off;
    status[ST_FORCED]   = st_forced;
    status[ST_BLOCKED]  = blocked;
    status[ST_CAL]      = cal_now;
    status[ST_MON]      = mon_active;
    status[ST_MON_LP]   = mon_lp;
    status[ST_FAST_DCT] = fast_dct;
  end

  // ---------------------------------------------------------------
  // monitor converter
  // ---------------------------------------------------------------
  lmhc_mon_conv #(
    .DW (SAMPLE_W)
  ) u_conv (
    .pclk              (pclk),
    .presetn           (presetn),
    .fs_tick           (fs_tick),
    .enable            (mon_active),
    .lowpower          (mon_lp),
    .atten_sel         (ctrl_q.receive_gain_select),  // [RL4]
    .sample_in         (smp_q),
    .serial_sample_out (serial_sample_out),
    .serial_frame      (serial_frame),
    .sample_q          (last_sample)
  );

endmodule
`default_nettype wire

//--- lmhc_top_properties.sv
// concurrent checks on the ports of the line monitor and hook block
// assumes it is bound to lmhc_top, one pclk domain
`timescale 1ns/100ps
`default_nettype none
module lmhc_top_properties
  import lmhc_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic [LEVEL_W-1:0] line_level_pin,
  input wire lmhc_line_t         line_ctl,
  input wire logic               serial_sample_out,
  input wire logic               serial_frame
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SER_GAP: assert property (
    serial_frame |=> (!serial_frame) [*8]) else $error("frame pulses too close");
  AST_SER_IDLE: assert property (
    serial_frame |-> ##16 !serial_sample_out) else $error("serial line busy after word");
  AST_FRAME_POW: assert property (
    serial_frame |-> (line_ctl.monitor_power_normal || line_ctl.monitor_power_lowpower
      || $past(line_ctl.monitor_power_normal || line_ctl.monitor_power_lowpower)))
    else $error("samples sent with converter off");
  AST_POW_EXCL: assert property (
    !(line_ctl.monitor_power_normal && line_ctl.monitor_power_lowpower)) else $error("both converters on");
  AST_OVL_TERM: assert property (
    line_ctl.present_800_ohm |-> !line_ctl.dc_term_enable && line_ctl.hookswitch_current_reduce)
    else $error("overload outputs disagree");
  AST_OVL_LEVEL: assert property (
    $rose(line_ctl.present_800_ohm) |-> line_ctl.hook_drive && $past(line_level_pin, 4) == OVERLOAD_LEVEL)
    else $error("overload without full level");
  AST_CAL_BLOCK: assert property (
    line_ctl.calibrating |-> line_ctl.data_path_block) else $error("calibration with data open");
  AST_SETTLE_MIN: assert property (
    $rose(line_ctl.data_path_block && line_ctl.hook_drive)
    |-> (line_ctl.data_path_block || !line_ctl.hook_drive) [*8]) else $error("block too short");
  AST_SETTLE_END: assert property (
    $rose(line_ctl.data_path_block && line_ctl.hook_drive)
    |-> ##[1:300] !(line_ctl.data_path_block && line_ctl.hook_drive)) else $error("block never ends");
endmodule

bind lmhc_top lmhc_top_properties u_props (
  .pclk(pclk), .presetn(presetn), .line_level_pin(line_level_pin),
  .line_ctl(line_ctl), .serial_sample_out(serial_sample_out), .serial_frame(serial_frame)
);
`default_nettype wire

//--- lmhc_line_model.sv
// behavioural telephone line: ring edges, line level, ring samples
// assumes the bench asks for edges by one-cycle requests on pclk
`timescale 1ns/100ps
`default_nettype none
module lmhc_line_model
  import lmhc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                pos_req,
  input  wire logic                neg_req,
  input  wire logic [LEVEL_W-1:0]  level_set,
  input  wire logic [SAMPLE_W-1:0] sample_set,
  output logic                     ring_edge_pos_pin,
  output logic                     ring_edge_neg_pin,
  output logic [LEVEL_W-1:0]       line_level_pin,
  output logic [SAMPLE_W-1:0]      ring_inputs
);
  logic [2:0] pos_q = 3'h0;
  logic [2:0] neg_q = 3'h0;
  // a reversal is one edge, a ring repeats; pulses last 4 pclk so the sync sees them
  always @(posedge pclk) begin
    pos_q <= pos_req ? 3'h4 : pos_q - 3'(pos_q != 3'h0);
    neg_q <= neg_req ? 3'h4 : neg_q - 3'(neg_q != 3'h0);
  end
  // level and samples held stable between bench updates, no offset removal
  assign ring_edge_pos_pin = (pos_q != 3'h0);
  assign ring_edge_neg_pin = (neg_q != 3'h0);
  assign line_level_pin    = level_set;
  assign ring_inputs       = sample_set;
endmodule
`default_nettype wire

//--- lmhc_top_tb.sv
// self-checking bench of the line monitor and hook block
// assumes small FS_DIV and tick counts to keep the run short
`timescale 1ns/100ps
`default_nettype none
module lmhc_top_tb;
  import lmhc_pkg::*;
  localparam int DIV = 32;
  localparam int OHT = 4;
  localparam int CLT = 3;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready, pslverr;
  logic                pos_req = 1'b0, neg_req = 1'b0;
  logic [LEVEL_W-1:0]  level_set = 5'h10;
  logic [SAMPLE_W-1:0] sample_set = 16'h0100;
  logic                pos_pin, neg_pin, sso, sfr;
  logic [LEVEL_W-1:0]  lvl_pin;
  logic [SAMPLE_W-1:0] rng;
  lmhc_line_t          lc;
  logic [31:0]         rdat;
  logic                rerr;
  int                  n_mismatch = 0, check_count = 0, cyc = 0;
  int                  coef [8] = '{256, 228, 198, 171, 144, 256, 256, 256};

  lmhc_top #(.FS_DIV(DIV), .OFFHOOK_TICKS(OHT), .CAL_TICKS(CLT)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ring_edge_pos_pin(pos_pin), .ring_edge_neg_pin(neg_pin), .line_level_pin(lvl_pin),
    .ring_inputs(rng), .line_ctl(lc), .serial_sample_out(sso), .serial_frame(sfr));
  lmhc_line_model u_line (
    .pclk(pclk), .pos_req(pos_req), .neg_req(neg_req), .level_set(level_set),
    .sample_set(sample_set), .ring_edge_pos_pin(pos_pin), .ring_edge_neg_pin(neg_pin),
    .line_level_pin(lvl_pin), .ring_inputs(rng));

  // ---------------------------------------------------------------
  // clock, timeout and helpers
  // ---------------------------------------------------------------
  initial begin
    forever #20 pclk = ~pclk;
  end
  // a hang ends the run as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat & m, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic edge_req(input logic neg);
    @(posedge pclk);
    pos_req <= !neg;
    neg_req <= neg;
    @(posedge pclk);
    pos_req <= 1'b0;
    neg_req <= 1'b0;
    repeat (8) @(posedge pclk); // wait before classifying
  endtask
  // collect one serial word, msb first from the frame pulse
  task automatic get_word(output logic [15:0] w);
    while (sfr !== 1'b1) begin
      @(negedge pclk);
    end
    for (int i = 15; i >= 0; i--) begin
      w[i] = sso;
      @(negedge pclk);
    end
  endtask
  // samples are multiples of 256 so attenuation is exact
  function automatic logic [15:0] att(input logic [15:0] s, input logic [2:0] g, input logic lp);
    return lp ? 16'((s >> 8) * coef[g]) : s;
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] ctrl;
    logic [15:0] w;
    logic        lp;
    int          nf;
    void'($urandom(57686));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(ADDR_CTRL, 32'hffffffff, 32'h0);
    chk_rd(ADDR_STATUS, 32'h7, 32'h0);
    wr(8'h10, 32'h3);
    check({31'h0, rerr}, 32'h1);
    check(rdat, 32'h0);
    // edge flags, negative edges only in full-wave mode
    edge_req(1'b0);
    chk_rd(ADDR_STATUS, 32'h3, 32'h1);
    edge_req(1'b1);
    chk_rd(ADDR_STATUS, 32'h3, 32'h1);
    wr(ADDR_CTRL, 32'h10);
    edge_req(1'b1);
    check(32'(lc.full_wave_mode), 32'h1);
    chk_rd(ADDR_STATUS, 32'h3, 32'h3);
    wr(ADDR_STATUS, 32'h3);
    chk_rd(ADDR_STATUS, 32'h3, 32'h0);
    // every gain code on the low-power converter, then the normal one
    for (int g = 0; g < 9; g++) begin
      lp = (g < 8);
      ctrl = (32'(3'(g)) << 7) | 32'h8 | (lp ? 32'h4 : 32'h0);
      wr(ADDR_CTRL, 32'h8);
      sample_set <= 16'($urandom_range(1, 127)) << 8;
      wr(ADDR_CTRL, ctrl);
      wr(ADDR_CTRL, ctrl | 32'h1);
      settle(2 * DIV);
      get_word(w);
      check(32'(w), 32'(att(sample_set, 3'(g), lp)));
      check(32'(lc.monitor_power_lowpower), 32'(lp));
      check(32'(lc.monitor_power_normal), 32'(!lp));
      check(32'(lc.ac_coupling_reset), 32'h1);
      chk_rd(ADDR_SAMPLE, 32'hffff, 32'(att(sample_set, 3'(g), lp)));
      wr(ADDR_CTRL, 32'h0);
    end
    // off-hook counter with and without calibration
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_CTRL, c ? 32'h22 : 32'h2);
      settle(2);
      check(32'(lc.data_path_block), 32'h1);
      check(32'(lc.calibrating), 32'(c == 0));
      settle((OHT - 1) * DIV - 8);
      check(32'(lc.data_path_block), 32'h1);
      settle(2 * DIV);
      check(32'(lc.data_path_block), 32'h0);
      check(32'(lc.hook_drive), 32'h1);
      if (c == 0) begin
        wr(ADDR_CTRL, 32'h0);
      end
    end
    // forced on-hook, level read, no serial samples while forced, quick return, fast termination, then recalibration
    level_set <= 5'($urandom_range(0, 30));
    wr(ADDR_CTRL, 32'h26);
    settle(3);
    check(32'(lc.hook_drive), 32'h0);
    chk_rd(ADDR_LEVEL, 32'h1f, 32'(level_set));
    wr(ADDR_CTRL, 32'h27);
    nf = 0;
    for (int i = 0; i < 3 * DIV; i++) begin
      @(negedge pclk);
      nf += int'(sfr === 1'b1);
    end
    check(32'(nf), 32'h0);
    wr(ADDR_CTRL, 32'h22);
    settle(3);
    check(32'(lc.hook_drive), 32'h1);
    check(32'(lc.data_path_block), 32'h0);
    wr(ADDR_CTRL, 32'h23);
    settle(2);
    check(32'(lc.fast_dct_mode), 32'h1);
    wr(ADDR_CTRL, 32'h22);
    wr(ADDR_CTRL, 32'h6);
    wr(ADDR_CTRL, 32'h2);
    settle(3);
    check(32'(lc.calibrating), 32'h1);
    settle((CLT + 1) * DIV);
    check(32'(lc.data_path_block), 32'h0);
    // overload only with protection on, flag stays until cleared
    level_set <= OVERLOAD_LEVEL;
    settle(6);
    check(32'(lc.present_800_ohm), 32'h0);
    wr(ADDR_CTRL, 32'h42);
    settle(4);
    check(32'({lc.present_800_ohm, lc.dc_term_enable, lc.hookswitch_current_reduce}), 32'h5);
    chk_rd(ADDR_STATUS, 32'h4, 32'h4);
    wr(ADDR_CTRL, 32'h2);
    settle(3);
    check(32'(lc.present_800_ohm), 32'h0);
    chk_rd(ADDR_STATUS, 32'h4, 32'h4);
    wr(ADDR_STATUS, 32'h4);
    chk_rd(ADDR_STATUS, 32'h4, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
